// ---- rtl/cdio_pkg.sv ----
// Shared constants and types of the card deactivation and I/O steering block.
package cdio_pkg;

    // Default lengths of the four deactivation intervals, in device clock cycles.
    localparam int unsigned DEACT_T1_CYCLES = 32'd8;
    localparam int unsigned DEACT_T2_CYCLES = 32'd8;
    localparam int unsigned DEACT_T3_CYCLES = 32'd8;
    localparam int unsigned DEACT_T4_CYCLES = 32'd8;
    localparam int unsigned DEACT_CNT_WIDTH = 32'd16;

    // Number of host/card line pairs: data, auxiliary 1, auxiliary 2.
    localparam int unsigned LINE_PAIRS = 32'd3;

    // Values taken by the card-facing outputs and the interrupt line at reset.
    localparam logic RESET_CARD_RST  = 1'b0;
    localparam logic RESET_CARD_CLK  = 1'b0;
    localparam logic RESET_VCC_ON    = 1'b0;
    localparam logic RESET_RECEPTION = 1'b0;
    localparam logic RESET_IRQ_N     = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SESSION,
        ST_DEACT_RST,
        ST_DEACT_CLK,
        ST_DEACT_IO,
        ST_DEACT_VCC
    } cdio_state_t;

    typedef enum logic [1:0] {
        DIR_NEUTRAL,
        DIR_HOST_IN,
        DIR_CARD_IN
    } cdio_dir_t;

endpackage

// ---- rtl/cdio_line_pair.sv ----
// Direction steering of one host/card line pair.
`timescale 1ns/100ps
module cdio_line_pair
    import cdio_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_core_n,
    input  wire logic reception_on,
    input  wire logic host_in,
    output logic      host_out,
    output logic      host_oe,
    input  wire logic card_in,
    output logic      card_out,
    output logic      card_oe
);

    logic [1:0] host_sync_q;
    logic [1:0] card_sync_q;
    logic       host_prev_q;
    logic       card_prev_q;
    cdio_dir_t  dir_q;
    cdio_dir_t  dir_d;
    logic       host_out_d;
    logic       host_oe_d;
    logic       card_out_d;
    logic       card_oe_d;

    // Both pins come from outside the clock domain; edges are seen on the second stage only.
    always_ff @(posedge clock or negedge rst_core_n) begin
        if (!rst_core_n) begin
            host_sync_q <= 2'h3;
            card_sync_q <= 2'h3;
            host_prev_q <= 1'b1;
            card_prev_q <= 1'b1;
        end else begin
            host_sync_q <= {host_sync_q[0], host_in};
            card_sync_q <= {card_sync_q[0], card_in};
            host_prev_q <= host_sync_q[1];
            card_prev_q <= card_sync_q[1];
        end
    end

    always_comb begin
        dir_d      = dir_q;
        host_out_d = 1'b1;
        host_oe_d  = 1'b0;
        card_out_d = 1'b1;
        card_oe_d  = 1'b0;
        if (!reception_on) begin
            // Card line held low outside reception, host line left high.
            dir_d      = DIR_NEUTRAL;
            card_out_d = 1'b0;
            card_oe_d  = 1'b1;
        end else begin
            unique case (dir_q)
                DIR_NEUTRAL: begin
                    // A simultaneous fall on both sides favours the host.
                    if (host_prev_q && !host_sync_q[1]) begin
                        dir_d = DIR_HOST_IN;
                    end else if (card_prev_q && !card_sync_q[1]) begin
                        dir_d = DIR_CARD_IN;
                    end
                end
                DIR_HOST_IN: begin
                    card_out_d = host_sync_q[1];
                    card_oe_d  = 1'b1;
                    if (!host_prev_q && host_sync_q[1]) begin
                        dir_d = DIR_NEUTRAL;
                    end
                end
                DIR_CARD_IN: begin
                    host_out_d = card_sync_q[1];
                    host_oe_d  = 1'b1;
                    if (!card_prev_q && card_sync_q[1]) begin
                        dir_d = DIR_NEUTRAL;
                    end
                end
                default: begin
                    dir_d = DIR_NEUTRAL;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_core_n) begin
        if (!rst_core_n) begin
            dir_q    <= DIR_NEUTRAL;
            host_out <= 1'b1;
            host_oe  <= 1'b0;
            card_out <= 1'b0;
            card_oe  <= 1'b1;
        end else begin
            dir_q    <= dir_d;
            host_out <= host_out_d;
            host_oe  <= host_oe_d;
            card_out <= card_out_d;
            card_oe  <= card_oe_d;
        end
    end

endmodule

// ---- rtl/cdio_top.sv ----
// Card deactivation sequencer, interrupt line and host/card line steering.
`timescale 1ns/100ps
// How it works
// - Host raising the session command starts card deactivation.
// - Any fault or card removal during a session starts deactivation automatically.
// - First interval after the trigger ends with card reset driven low.
// - Second interval ends with the card clock forced low.
// - Third interval ends reception and drives the card data line low.
// - Fourth interval ends with card supply switched off; it then discharges.
// - Outside a session, with the session command high, the interrupt line shows card presence.
// - Outside a session faults neither touch the interrupt nor deactivate.
// - In a session removal or any fault pulls the interrupt line low.
// - Interrupt falls in the same cycle a fault or removal launches deactivation.
// - Card data and auxiliary lines low after reset, high under reception.
// - Host data and auxiliary lines stay high after reset.
// - First line falling in a pair becomes input, the other output.
// - Rising edge on the input line returns the pair to neutral.
// - Session command acts on edges only; falling edge requests activation.
module cdio_top
    import cdio_pkg::*;
#(
    parameter int unsigned T1_CYCLES = DEACT_T1_CYCLES,
    parameter int unsigned T2_CYCLES = DEACT_T2_CYCLES,
    parameter int unsigned T3_CYCLES = DEACT_T3_CYCLES,
    parameter int unsigned T4_CYCLES = DEACT_T4_CYCLES,
    parameter int unsigned CNT_W     = DEACT_CNT_WIDTH
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic session_command_n,
    input  wire logic card_detect_input,
    input  wire logic overcurrent_fault,
    input  wire logic overtemp_fault,
    input  wire logic vdd_fault,
    input  wire logic vcc_fault,
    input  wire logic host_card_reset_request,
    input  wire logic act_reception_on,
    input  wire logic act_clock_on,
    input  wire logic act_reset_allow,
    output logic      session_active,
    output logic      irq_n,
    output logic      card_reset_out,
    output logic      card_clock_enable,
    output logic      card_vcc_enable,
    output logic      reception_on,
    input  wire logic host_data_line_in,
    output logic      host_data_line_out,
    output logic      host_data_line_oe,
    input  wire logic host_aux_line_1_in,
    output logic      host_aux_line_1_out,
    output logic      host_aux_line_1_oe,
    input  wire logic host_aux_line_2_in,
    output logic      host_aux_line_2_out,
    output logic      host_aux_line_2_oe,
    input  wire logic card_data_line_in,
    output logic      card_data_line_out,
    output logic      card_data_line_oe,
    input  wire logic card_aux_line_1_in,
    output logic      card_aux_line_1_out,
    output logic      card_aux_line_1_oe,
    input  wire logic card_aux_line_2_in,
    output logic      card_aux_line_2_out,
    output logic      card_aux_line_2_oe
);

    localparam int unsigned CNT_MAX = (32'd1 << CNT_W) - 32'd1;

    // Zero-length intervals would collapse two steps into one edge, so they are refused.
    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
        $error("cdio_top: CNT_W out of range");
    end
    if (T1_CYCLES < 1 || T2_CYCLES < 1 || T3_CYCLES < 1 || T4_CYCLES < 1 ||
        T1_CYCLES > CNT_MAX || T2_CYCLES > CNT_MAX ||
        T3_CYCLES > CNT_MAX || T4_CYCLES > CNT_MAX) begin : g_bad_interval
        $error("cdio_top: deactivation interval out of range");
    end

    localparam logic [CNT_W-1:0] T1_LOAD = CNT_W'(T1_CYCLES - 32'd1);
    localparam logic [CNT_W-1:0] T2_LOAD = CNT_W'(T2_CYCLES - 32'd1);
    localparam logic [CNT_W-1:0] T3_LOAD = CNT_W'(T3_CYCLES - 32'd1);
    localparam logic [CNT_W-1:0] T4_LOAD = CNT_W'(T4_CYCLES - 32'd1);

    logic             rst_meta_q;
    logic             rst_core_n;
    logic [6:0]       pin_meta_q;
    logic [6:0]       pin_sync_q;
    logic             cmd_prev_q;
    logic             cmd_s;
    logic             present_s;
    logic             fault_s;
    logic             rst_req_s;
    logic             cmd_fall;
    logic             cmd_rise;
    logic             trigger;
    cdio_state_t      state_q;
    cdio_state_t      state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             fault_hold_q;
    logic             fault_hold_d;
    logic             irq_n_d;
    logic             card_rst_d;
    logic             card_clk_d;
    logic             vcc_d;
    logic             recep_d;
    logic [2:0]       host_in_v;
    logic [2:0]       host_out_v;
    logic [2:0]       host_oe_v;
    logic [2:0]       card_in_v;
    logic [2:0]       card_out_v;
    logic [2:0]       card_oe_v;

    // Reset is applied at once but released on the second rising clock edge, in step with the clock.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_core_n <= rst_meta_q;
        end
    end

    // Pins from the host and the supervisors pass two flip-flops before use.
    always_ff @(posedge clock or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pin_meta_q <= 7'h01;
            pin_sync_q <= 7'h01;
            cmd_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {host_card_reset_request, vcc_fault, vdd_fault, overtemp_fault,
                           overcurrent_fault, card_detect_input, session_command_n};
            pin_sync_q <= pin_meta_q;
            cmd_prev_q <= pin_sync_q[0];
        end
    end

    assign cmd_s     = pin_sync_q[0];
    assign present_s = pin_sync_q[1];
    assign fault_s   = |pin_sync_q[5:2] | ~present_s;
    assign rst_req_s = pin_sync_q[6];
    // Only edges of the session command count; reset loads it high, so a low level held through reset counts as a fall.
    assign cmd_fall  = cmd_prev_q & ~cmd_s;
    assign cmd_rise  = ~cmd_prev_q & cmd_s;
    assign trigger   = cmd_rise | fault_s;

    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        fault_hold_d = fault_hold_q;
        card_rst_d   = card_reset_out;
        card_clk_d   = card_clock_enable;
        vcc_d        = card_vcc_enable;
        recep_d      = reception_on;
        unique case (state_q)
            ST_IDLE: begin
                // Faults here are ignored: no deactivation and no effect on the interrupt.
                card_rst_d = 1'b0;
                card_clk_d = 1'b0;
                vcc_d      = 1'b0;
                recep_d    = 1'b0;
                if (cmd_s) begin
                    fault_hold_d = 1'b0;
                end
                if (cmd_fall && present_s) begin
                    state_d = ST_SESSION;
                    vcc_d   = 1'b1;
                end
            end
            ST_SESSION: begin
                card_rst_d = act_reset_allow & rst_req_s;
                card_clk_d = act_clock_on;
                recep_d    = act_reception_on;
                if (trigger) begin
                    // Same decision launches the sequence and, for a fault or removal, drops the interrupt.
                    state_d      = ST_DEACT_RST;
                    cnt_d        = T1_LOAD;
                    fault_hold_d = fault_s;
                end
            end
            ST_DEACT_RST: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    card_rst_d = 1'b0;
                    state_d    = ST_DEACT_CLK;
                    cnt_d      = T2_LOAD;
                end
            end
            ST_DEACT_CLK: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    card_clk_d = 1'b0;
                    state_d    = ST_DEACT_IO;
                    cnt_d      = T3_LOAD;
                end
            end
            ST_DEACT_IO: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    recep_d = 1'b0;
                    state_d = ST_DEACT_VCC;
                    cnt_d   = T4_LOAD;
                end
            end
            ST_DEACT_VCC: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0) begin
                    // Supply discharge afterwards is analog and not timed here.
                    vcc_d   = 1'b0;
                    state_d = ST_IDLE;
                    cnt_d   = '0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A fault latched in the session keeps the line low until the host ends it.
        if (fault_hold_d) begin
            irq_n_d = 1'b0;
        end else if (state_d == ST_IDLE && cmd_s) begin
            irq_n_d = present_s;
        end else begin
            irq_n_d = irq_n;
        end
    end

    always_ff @(posedge clock or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_q           <= ST_IDLE;
            cnt_q             <= '0;
            fault_hold_q      <= 1'b0;
            irq_n             <= RESET_IRQ_N;
            card_reset_out    <= RESET_CARD_RST;
            card_clock_enable <= RESET_CARD_CLK;
            card_vcc_enable   <= RESET_VCC_ON;
            reception_on      <= RESET_RECEPTION;
        end else begin
            state_q           <= state_d;
            cnt_q             <= cnt_d;
            fault_hold_q      <= fault_hold_d;
            irq_n             <= irq_n_d;
            card_reset_out    <= card_rst_d;
            card_clock_enable <= card_clk_d;
            card_vcc_enable   <= vcc_d;
            reception_on      <= recep_d;
        end
    end

    assign session_active = (state_q != ST_IDLE);

    assign host_in_v = {host_aux_line_2_in, host_aux_line_1_in, host_data_line_in};
    assign card_in_v = {card_aux_line_2_in, card_aux_line_1_in, card_data_line_in};

    // Each pair steers independently; all share the reception state of the sequencer.
    for (genvar i = 0; i < LINE_PAIRS; i++) begin : g_pair
        cdio_line_pair u_pair (
            .clock        (clock),
            .rst_core_n   (rst_core_n),
            .reception_on (reception_on),
            .host_in      (host_in_v[i]),
            .host_out     (host_out_v[i]),
            .host_oe      (host_oe_v[i]),
            .card_in      (card_in_v[i]),
            .card_out     (card_out_v[i]),
            .card_oe      (card_oe_v[i])
        );
    end

    assign host_data_line_out  = host_out_v[0];
    assign host_data_line_oe   = host_oe_v[0];
    assign host_aux_line_1_out = host_out_v[1];
    assign host_aux_line_1_oe  = host_oe_v[1];
    assign host_aux_line_2_out = host_out_v[2];
    assign host_aux_line_2_oe  = host_oe_v[2];
    assign card_data_line_out  = card_out_v[0];
    assign card_data_line_oe   = card_oe_v[0];
    assign card_aux_line_1_out = card_out_v[1];
    assign card_aux_line_1_oe  = card_oe_v[1];
    assign card_aux_line_2_out = card_out_v[2];
    assign card_aux_line_2_oe  = card_oe_v[2];

endmodule

// ---- tb/cdio_monitor.sv ----
// Port checker of the card deactivation and line steering block.
`timescale 1ns/100ps
module cdio_monitor #(
    parameter int unsigned T1_CYCLES = 8,
    parameter int unsigned T3_CYCLES = 8,
    parameter int unsigned T4_CYCLES = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic session_command_n,
    input wire logic card_detect_input,
    input wire logic overcurrent_fault,
    input wire logic overtemp_fault,
    input wire logic vdd_fault,
    input wire logic vcc_fault,
    input wire logic session_active,
    input wire logic irq_n,
    input wire logic card_reset_out,
    input wire logic card_clock_enable,
    input wire logic card_vcc_enable,
    input wire logic reception_on,
    input wire logic host_data_line_in,
    input wire logic host_data_line_oe,
    input wire logic host_aux_line_1_oe,
    input wire logic host_aux_line_2_oe,
    input wire logic card_data_line_out,
    input wire logic card_data_line_oe,
    input wire logic card_aux_line_1_oe,
    input wire logic card_aux_line_2_oe
);
    localparam int D1 = T1_CYCLES - 1;
    localparam int D3 = T3_CYCLES - 1;
    localparam int D4 = T4_CYCLES - 1;
    wire logic flt_any = overcurrent_fault | overtemp_fault | vdd_fault | vcc_fault
                         | !card_detect_input;
    logic [3:0] quiet_q, quiet_d;
    logic       det_q,   det_d;
    // The quiet count lets the presence synchroniser settle before irq_n is judged.
    always_comb begin
        det_d   = card_detect_input;
        quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
        if (session_active || !session_command_n || card_detect_input != det_q) begin
            quiet_d = 4'h0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quiet_q <= 4'h0;
            det_q   <= 1'b0;
        end else begin
            quiet_q <= quiet_d;
            det_q   <= det_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_irq_presence: assert property (quiet_q >= 4'h8 |-> irq_n == card_detect_input)
        else $error("interrupt does not follow card presence");
    a_vcc_session: assert property (card_vcc_enable == session_active)
        else $error("card supply and session flag disagree");
    a_clk_after_rst: assert property ($fell(card_clock_enable) |-> !card_reset_out)
        else $error("card clock stopped before card reset");
    a_io_after_clk: assert property ($fell(reception_on) |-> !card_clock_enable)
        else $error("reception left while card clock runs");
    a_rst_interval: assert property ($fell(irq_n) && session_active && card_reset_out
        |-> ##D1 card_reset_out ##1 !card_reset_out) else $error("card reset fall mistimed");
    a_rec_interval: assert property ($fell(card_clock_enable) && !card_reset_out
        |-> ##D3 reception_on ##1 !reception_on) else $error("reception end mistimed");
    a_vcc_interval: assert property ($fell(reception_on)
        |-> ##D4 card_vcc_enable ##1 !card_vcc_enable) else $error("supply off mistimed");
    a_fault_irq: assert property (session_active && !session_command_n && $rose(flt_any)
        |-> ##[1:4] !irq_n) else $error("session fault not reported");
    a_card_low_off: assert property (!reception_on && !$past(reception_on)
        |-> card_data_line_oe && !card_data_line_out && card_aux_line_1_oe
        && card_aux_line_2_oe) else $error("card lines not held low");
    a_host_free: assert property (!reception_on && !$past(reception_on)
        |-> !host_data_line_oe && !host_aux_line_1_oe && !host_aux_line_2_oe)
        else $error("host lines driven outside reception");
    a_pair_excl: assert property (!(host_data_line_oe && card_data_line_oe && reception_on))
        else $error("both data lines driven");
    a_drive_low: assert property ($rose(card_data_line_oe) && reception_on
        |-> !card_data_line_out) else $error("card line driven with wrong level");
    a_neutral_back: assert property (reception_on && card_data_line_oe
        && $rose(host_data_line_in) |-> ##[1:4] !card_data_line_oe)
        else $error("pair did not return to neutral");
    c_supply_off: cover property ($fell(card_vcc_enable));
    c_fault_deact: cover property ($fell(irq_n) && session_active);
    c_card_driven: cover property ($rose(card_data_line_oe) && reception_on);
endmodule
bind cdio_top cdio_monitor #(.T1_CYCLES(T1_CYCLES), .T3_CYCLES(T3_CYCLES),
    .T4_CYCLES(T4_CYCLES)) cdio_monitor_i (.*);

// ---- tb/cdio_host_model.sv ----
// Host controller model driving the session command and card reset request.
`timescale 1ns/100ps
module cdio_host_model (
    input  wire logic clock,
    output logic      session_command_n,
    output logic      host_card_reset_request
);
    initial begin
        session_command_n = 1'b1;
        host_card_reset_request = 1'b1;
    end
    // The command counts only on its edges, so activation is a fall from high.
    task automatic activate();
        @(negedge clock);
        session_command_n = 1'b0;
    endtask
    task automatic deactivate();
        @(negedge clock);
        session_command_n = 1'b1;
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the card deactivation and line steering block.
`timescale 1ns/100ps
module tb;
    import cdio_pkg::*;
    localparam int unsigned T1 = 3, T2 = 4, T3 = 5, T4 = 2;
    int         tl[4] = '{T1, T2, T3, T4};
    logic       clock = 1'b0, rst_n = 1'b0, detect = 1'b0, cmd_n, rreq;
    logic [3:0] fault = 4'h0;
    logic [2:0] act = 3'h7, h_drv = 3'h7, c_drv = 3'h7;
    logic [2:0] h_pin, c_pin, h_out, h_oe, c_out, c_oe;
    logic       sess, irq_n, c_rst, c_clk, c_vcc, rec;
    int         cyc = 0, n_mismatch = 0, checks = 0;
    // Undriven host lines sit on their pull-up, here the bench's idle high.
    assign h_pin = (h_oe & h_out) | (~h_oe & h_drv);
    assign c_pin = (c_oe & c_out) | (~c_oe & c_drv);
    always #2 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    cdio_host_model cdio_host_model_i (.clock(clock), .session_command_n(cmd_n),
        .host_card_reset_request(rreq));
    cdio_top #(.T1_CYCLES(T1), .T2_CYCLES(T2), .T3_CYCLES(T3), .T4_CYCLES(T4)) cdio_top_i (
        .clock(clock), .rst_n(rst_n), .session_command_n(cmd_n), .card_detect_input(detect),
        .overcurrent_fault(fault[0]), .overtemp_fault(fault[1]), .vdd_fault(fault[2]),
        .vcc_fault(fault[3]), .host_card_reset_request(rreq), .act_reception_on(act[0]),
        .act_clock_on(act[1]), .act_reset_allow(act[2]), .session_active(sess),
        .irq_n(irq_n), .card_reset_out(c_rst), .card_clock_enable(c_clk),
        .card_vcc_enable(c_vcc), .reception_on(rec),
        .host_data_line_in(h_pin[0]), .host_data_line_out(h_out[0]),
        .host_data_line_oe(h_oe[0]), .host_aux_line_1_in(h_pin[1]),
        .host_aux_line_1_out(h_out[1]), .host_aux_line_1_oe(h_oe[1]),
        .host_aux_line_2_in(h_pin[2]), .host_aux_line_2_out(h_out[2]),
        .host_aux_line_2_oe(h_oe[2]), .card_data_line_in(c_pin[0]),
        .card_data_line_out(c_out[0]), .card_data_line_oe(c_oe[0]),
        .card_aux_line_1_in(c_pin[1]), .card_aux_line_1_out(c_out[1]),
        .card_aux_line_1_oe(c_oe[1]), .card_aux_line_2_in(c_pin[2]),
        .card_aux_line_2_out(c_out[2]), .card_aux_line_2_oe(c_oe[2]));
    task automatic cmp_b(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: level %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_c(input int got, input int exp);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("Error %0t: event cycle %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Reception is held off for a random while so the card lines must wait for it.
    task automatic start();
        act[0] = 1'b0;
        cdio_host_model_i.activate();
        repeat (6 + $urandom % 4) @(negedge clock);
        cmp_b(sess, 1'b1);
        cmp_b(rec, 1'b0);
        cmp_b(c_oe[0] & ~c_out[0], 1'b1);
        act[0] = 1'b1;
        repeat (3) @(negedge clock);
        cmp_b(rec, 1'b1);
        cmp_b(c_oe[0], 1'b0);
    endtask
    // One pulse on the chosen side; the other side must follow, then go neutral.
    task automatic pair(input int p, input bit from_host);
        int len;
        len = $urandom % 8;
        if (from_host) h_drv[p] = 1'b0;
        else c_drv[p] = 1'b0;
        repeat (5) @(negedge clock);
        cmp_b(from_host ? c_oe[p] : h_oe[p], 1'b1);
        cmp_b(from_host ? c_out[p] : h_out[p], 1'b0);
        cmp_b(from_host ? h_oe[p] : c_oe[p], 1'b0);
        repeat (len) @(negedge clock);
        h_drv[p] = 1'b1;
        c_drv[p] = 1'b1;
        repeat (5) @(negedge clock);
        cmp_b(c_oe[p] | h_oe[p], 1'b0);
    endtask
    // Kind 0 is the host command, 1 to 4 a fault input, 5 card removal.
    task automatic deact(input int kind);
        int a;
        int got[5];
        int exp[$];
        logic [4:0] lv;
        got = '{default: -1};
        if (kind == 0) cdio_host_model_i.deactivate();
        else @(negedge clock);
        if (kind > 0 && kind < 5) fault[kind-1] = 1'b1;
        if (kind == 5) detect = 1'b0;
        a = cyc + 1;
        exp.push_back(a + 2 + T1);
        for (int k = 1; k < 4; k++) exp.push_back(exp[k-1] + tl[k]);
        exp.push_back(kind > 0 ? a + 2 : -1);
        for (int i = 0; i < 60; i++) begin
            @(negedge clock);
            lv = {irq_n, c_vcc, rec, c_clk, c_rst};
            for (int k = 0; k < 5; k++) if (lv[k] === 1'b0 && got[k] < 0) got[k] = cyc;
        end
        for (int k = 0; k < 5; k++) cmp_c(got[k], exp[k]);
        cmp_b(sess, 1'b0);
    endtask
    initial begin
        void'($urandom(70519));
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        for (int p = 0; p < 3; p++) begin
            cmp_b(c_oe[p] & ~c_out[p], 1'b1);
            cmp_b(h_oe[p], 1'b0);
        end
        cmp_b(irq_n, 1'b0);
        cdio_host_model_i.activate();
        repeat (6) @(negedge clock);
        cmp_b(sess, 1'b0);
        cdio_host_model_i.deactivate();
        detect = 1'b1;
        repeat (8) @(negedge clock);
        cmp_b(irq_n, 1'b1);
        fault = 4'hf;
        repeat (8) @(negedge clock);
        cmp_b(irq_n | sess, 1'b1);
        cmp_b(sess, 1'b0);
        fault = 4'h0;
        start();
        for (int p = 0; p < 3; p++) begin
            pair(p, 1'b1);
            pair(p, 1'b0);
        end
        deact(0);
        for (int k = 1; k <= 5; k++) begin
            repeat ($urandom % 4) @(negedge clock);
            start();
            deact(k);
            fault = 4'h0;
            detect = 1'b1;
            cdio_host_model_i.deactivate();
            repeat (10) @(negedge clock);
            cmp_b(irq_n, 1'b1);
        end
        results();
    end
    // The tests need under a thousand cycles; this allows about five times that.
    initial begin
        #20000;
        n_mismatch++;
        results();
    end
endmodule
